/* File: bench/ubds_core_tb.sv */
// self-checking bench for the baud, dma and sleep core
`timescale 1ns/1ps
module ubds_core_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic irq_other_pending = 1'b0;
    logic kick = 1'b0;
    logic [3:0] mnext = 4'h0;
    wire [31:0] avs_readdata;
    wire avs_waitrequest, tx_dma_request, rx_dma_request, baud_tick, asleep, rx_line;
    wire [3:0] modem_in;
    wire [2:0] mon = {asleep, rx_dma_request, tx_dma_request};
    logic [31:0] r;
    int n_fail = 0;
    int checked = 0;
    int cyc = 0;
    int g;
    always #12.5 clk = ~clk;
    ubds_core DUT (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .rx_line(rx_line), .modem_in(modem_in),
        .irq_other_pending(irq_other_pending), .tx_dma_request(tx_dma_request),
        .rx_dma_request(rx_dma_request), .baud_tick(baud_tick), .asleep(asleep));
    ubds_line_model u_line (.clk(clk), .rst(rst), .rx_kick(kick), .modem_next(mnext),
        .rx_line(rx_line), .modem_in(modem_in));
    // ****************
    // tasks
    // ****************
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic acc(input logic rw, input logic [3:0] ad, input logic [7:0] d);
        @(posedge clk);
        avs_address <= ad;
        avs_writedata <= {24'h0, d};
        avs_write <= rw;
        avs_read <= !rw;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        r = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic ev(input int b);
        acc(1'b1, 4'h8, 8'h1 << b);
    endtask
    task automatic wt(input string nm, input int b, input logic v);
        int k;
        k = 0;
        while (mon[b] !== v && k < 2000) begin
            @(posedge clk);
            #1;
            k++;
        end
        chk(nm, mon[b], v);
    endtask
    task automatic gap(input int e);
        // skip ticks still timed by the old setting
        repeat (3) @(posedge baud_tick);
        g = 0;
        do begin
            @(posedge clk);
            #1;
            g++;
        end while (baud_tick !== 1'b1 && g < 400);
        chk("tick_gap", g, e);
    endtask
    task automatic still(input string nm, input int b, input logic v);
        repeat (40) @(posedge clk);
        chk(nm, mon[b], v);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_fail++;
            complete_run();
        end
    end
    // ****************
    // main sequence
    // ****************
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk("rx_req_reset", rx_dma_request, 1'b0);
        acc(1'b0, 4'h2, 8'h0);
        chk("modem_ctrl_reset", r, 32'h0);
        acc(1'b0, 4'hf, 8'h0);
        chk("unmapped", r, 32'h0);
        acc(1'b1, 4'h4, 8'h10);
        acc(1'b1, 4'h0, 8'h03);
        acc(1'b1, 4'h1, 8'h00);
        gap(3);
        acc(1'b1, 4'h2, 8'h80);
        gap(12);
        acc(1'b1, 4'h2, 8'h00);
        gap(3);
        acc(1'b1, 4'h0, 8'h00);
        repeat (2) @(posedge clk);
        g = 0;
        repeat (300) begin
            @(posedge clk);
            #1;
            g += baud_tick;
        end
        chk("zero_div_ticks", g, 0);
        acc(1'b1, 4'h1, 8'h01);
        gap(256);
        acc(1'b1, 4'h0, 8'h02);
        acc(1'b1, 4'h1, 8'h00);
        gap(2);
        acc(1'b1, 4'h3, 8'h08);
        wt("tx_single", 0, 1'b1);
        ev(0);
        wt("tx_single_load", 0, 1'b0);
        ev(3);
        wt("tx_single_empty", 0, 1'b1);
        ev(1);
        wt("rx_single", 1, 1'b1);
        ev(2);
        wt("rx_single_empty", 1, 1'b0);
        acc(1'b1, 4'h3, 8'h09);
        acc(1'b1, 4'h6, 8'h11);
        repeat (64) ev(0);
        wt("tx_block_full", 0, 1'b0);
        repeat (4) ev(3);
        wt("tx_block_space", 0, 1'b1);
        repeat (60) ev(3);
        repeat (3) ev(1);
        still("rx_below_trig", 1, 1'b0);
        ev(1);
        wt("rx_trig", 1, 1'b1);
        acc(1'b0, 4'h7, 8'h0);
        chk("rx_count", r[22:16], 32'h4);
        ev(4);
        wt("rx_error", 1, 1'b0);
        ev(5);
        repeat (4) ev(2);
        wt("rx_block_empty", 1, 1'b0);
        ev(1);
        wt("rx_timeout", 1, 1'b1);
        ev(2);
        wt("rx_timeout_pop", 1, 1'b0);
        acc(1'b1, 4'h3, 8'h00);
        still("no_sleep_disabled", 2, 1'b0);
        acc(1'b1, 4'h5, 8'h10);
        wt("sleep", 2, 1'b1);
        ev(0);
        wt("wake_tx", 2, 1'b0);
        ev(1);
        ev(3);
        still("no_sleep_rx_data", 2, 1'b0);
        ev(2);
        wt("sleep_again", 2, 1'b1);
        mnext <= 4'h5;
        wt("wake_modem", 2, 1'b0);
        wt("sleep_modem", 2, 1'b1);
        irq_other_pending <= 1'b1;
        kick <= 1'b1;
        @(posedge clk);
        kick <= 1'b0;
        wt("wake_rx", 2, 1'b0);
        still("no_sleep_irq", 2, 1'b0);
        irq_other_pending <= 1'b0;
        wt("sleep_final", 2, 1'b1);
        // leave sleep before touching the divisor
        acc(1'b1, 4'h5, 8'h00);
        wt("wake_disable", 2, 1'b0);
        acc(1'b1, 4'h0, 8'h05);
        gap(5);
        complete_run();
    end
endmodule
bind ubds_core ubds_props u_props (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rx_line(rx_line),
    .modem_in(modem_in), .irq_other_pending(irq_other_pending),
    .tx_dma_request(tx_dma_request), .rx_dma_request(rx_dma_request),
    .baud_tick(baud_tick), .asleep(asleep));

/* File: bench/ubds_line_model.sv */
// serial receive line and modem pins facing the core
`timescale 1ns/1ps
module ubds_line_model (
    input wire clk,
    input wire rst,
    input wire rx_kick,
    input wire [3:0] modem_next,
    output wire rx_line,
    output logic [3:0] modem_in
);
    logic [2:0] low_q;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            low_q <= 3'h0;
            modem_in <= 4'h0;
        end else begin
            low_q <= rx_kick ? 3'h4 : low_q - {2'h0, low_q != 3'h0};
            modem_in <= modem_next;
        end
    end
    // idle line rests high, a kick gives a short low pulse
    assign rx_line = (low_q == 3'h0);
endmodule

/* File: bench/ubds_props.sv */
// concurrent checks on the ports of the baud, dma and sleep core
`timescale 1ns/1ps
module ubds_props (
    input wire clk,
    input wire rst,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire rx_line,
    input wire [3:0] modem_in,
    input wire irq_other_pending,
    input wire tx_dma_request,
    input wire rx_dma_request,
    input wire baud_tick,
    input wire asleep
);
    // ****************
    // properties
    // ****************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire req = avs_read | avs_write;
    wire tx_evt = avs_write && !avs_waitrequest && avs_address == 4'h8 && avs_writedata[0];
    chk_bus_answer_one: assert property ($rose(req) |=> !avs_waitrequest)
        else $error("bus answer late");
    chk_bus_answer_short: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("bus answer held too long");
    chk_rdata_idle_zero: assert property (avs_waitrequest |-> avs_readdata == 32'h0)
        else $error("read data outside answer");
    chk_sleep_no_tick: assert property (asleep && $past(asleep) && $past(asleep, 2)
        |-> !baud_tick)
        else $error("tick while asleep");
    chk_irq_blocks_sleep: assert property (irq_other_pending && !asleep |=> !asleep)
        else $error("sleep entered with interrupt pending");
    chk_wake_tx_write: assert property (asleep && tx_evt |-> ##[1:4] !asleep)
        else $error("no wake on transmit write");
    chk_wake_rx_edge: assert property (asleep && $changed(rx_line) |-> ##[1:6] !asleep)
        else $error("no wake on receive edge");
    chk_wake_modem_pin: assert property (asleep && $changed(modem_in) |-> ##[1:6] !asleep)
        else $error("no wake on modem change");
    chk_sleep_rx_empty: assert property (asleep && $past(asleep) |-> !rx_dma_request)
        else $error("receive request while asleep");
    cover property ($rose(asleep));
    cover property ($rose(rx_dma_request));
    cover property ($fell(tx_dma_request));
endmodule

/* File: rtl/ubds_baud_gen.v */
// prescaler and 16-bit divisor producing the 16x tick
`timescale 1ns/1ps
`include "ubds_defs.vh"
module ubds_baud_gen #(
    parameter DW = 16
) (
    input wire clk,
    input wire rst,
    input wire run,
    input wire prescale_four,
    input wire [DW-1:0] divisor,
    output reg tick16
);
    reg [1:0] pre_q;
    reg [DW-1:0] cnt_q;
    wire pre_tick;

    assign pre_tick = prescale_four ? (pre_q == `UBDS_PRESCALE_DIV) : 1'b1;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pre_q <= 2'h0;
            cnt_q <= {DW{1'b0}};
            tick16 <= 1'b0;
        end else if (!run || divisor == {DW{1'b0}}) begin
            tick16 <= 1'b0;
            cnt_q <= {DW{1'b0}};
        end else begin
            pre_q <= pre_q + 2'h1;
            tick16 <= 1'b0;
            if (pre_tick) begin
                if (cnt_q >= divisor - {{(DW-1){1'b0}}, 1'b1}) begin
                    cnt_q <= {DW{1'b0}};
                    tick16 <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + {{(DW-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule

/* File: rtl/ubds_core.v */
// baud generator, dma request signalling and sleep control
// Functional notes
// - divisor from one to 65535
// - output tick at sixteen times bit rate
// - optional divide-by-four prescaler, modem control bit
// - divisor computed and loaded by software
// - divisor written as low and high bytes
// - zero divisor stops the baud clock
// - one tick times both transmit and receive
// - fifo control bit three selects dma mode when fifo enable bit zero is set
// - single mode tx request while slot empty
// - single mode rx request while data held
// - block mode tx request on free space
// - block rx request on trigger or timeout
// - sleep needs enhanced and sleep enable bits
// - sleep needs idle line, empty tx, no interrupts
// - no sleep while receive fifo holds data
// - sleep stops controller and baud clocks; here only the baud tick stops
// - wake on rx edge, modem change, tx write
// - rx timeout after four word plus twelve
`timescale 1ns/1ps
`include "ubds_defs.vh"
module ubds_core #(
    parameter DEPTH = 64,
    parameter CW = 7
) (
    input wire clk,
    input wire rst,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire rx_line,
    input wire [3:0] modem_in,
    input wire irq_other_pending,
    output reg tx_dma_request,
    output reg rx_dma_request,
    output reg baud_tick,
    output reg asleep
);
    // ****************************************
    // state
    // ****************************************
    reg [7:0] div_low_q;
    reg [7:0] divisor_high_byte_q;
    reg [7:0] modem_control_reg_q;
    reg [7:0] fifo_control_reg_q;
    reg [7:0] enhanced_feature_reg_q;
    reg [7:0] interrupt_enable_reg_q;
    reg [7:0] trigger_q;
    reg [CW-1:0] tx_count_q;
    reg [CW-1:0] rx_count_q;
    reg fifo_error_q;
    reg rx_timeout_q;
    reg [9:0] idle_cnt_q;
    reg rx_prev_q;
    reg [3:0] modem_prev_q;
    reg ack_q;
    wire rx_s;
    wire [3:0] modem_s;
    wire tick;
    wire [15:0] divisor;
    wire wr_req;
    wire rd_req;
    wire [CW-1:0] tx_trig;
    wire [CW-1:0] rx_trig;
    wire [CW-1:0] depth_c;
    wire block_mode;
    wire [9:0] timeout_bits;
    wire evt_wr;
    wire sleep_allowed;
    wire sleep_quiet;
    reg [CW-1:0] tx_count_d;
    reg [CW-1:0] rx_count_d;

    function [CW-1:0] trig_count;
        input [3:0] nib;
        begin
            trig_count = {{(CW-4){1'b0}}, nib} << 2;
        end
    endfunction

    function evt_bit;
        input [31:0] data;
        input integer pos;
        begin
            evt_bit = data[pos];
        end
    endfunction

    // ****************************************
    // pin synchronisers
    // ****************************************
    ubds_sync #(.W(5)) u_sync (
        .clk(clk),
        .rst(rst),
        .async_in({rx_line, modem_in}),
        .sync_out({rx_s, modem_s})
    );

    // sixteen-bit divisor for the 16x tick
    assign divisor = {divisor_high_byte_q, div_low_q};
    assign depth_c = DEPTH[CW-1:0];
    assign tx_trig = trig_count(trigger_q[3:0]);
    assign rx_trig = trig_count(trigger_q[7:4]);
    // writes land on the edge that ends the cycle after the wait state
    assign wr_req = avs_write && ack_q;
    assign rd_req = avs_read && !ack_q;
    assign evt_wr = wr_req && avs_address == `UBDS_ADDR_EVENT;
    assign block_mode = fifo_control_reg_q[`UBDS_FCR_DMA_MODE] &&
        fifo_control_reg_q[`UBDS_FCR_FIFO_EN];
    // four words plus twelve, in bit times
    assign timeout_bits = {2'h0, `UBDS_WORD_LEN, 2'h0} + {2'h0, `UBDS_TIMEOUT_BASE};

    // ****************************************
    // sleep conditions
    // ****************************************
    // both enable bits needed
    assign sleep_allowed = enhanced_feature_reg_q[`UBDS_EFR_ENHANCED] &&
        interrupt_enable_reg_q[`UBDS_IER_SLEEP];
    // idle line, empty fifos, no other interrupt
    assign sleep_quiet = rx_s && rx_prev_q && modem_s == modem_prev_q &&
        tx_count_d == {CW{1'b0}} && rx_count_d == {CW{1'b0}} &&
        !irq_other_pending && !wr_req;

    // ****************************************
    // baud generator
    // ****************************************
    // sleep stops the shared tick
    ubds_baud_gen #(.DW(16)) u_baud (
        .clk(clk),
        .rst(rst),
        .run(!asleep),
        .prescale_four(modem_control_reg_q[`UBDS_MCR_PRESCALE]),
        .divisor(divisor),
        .tick16(tick)
    );

    // ****************************************
    // bus slave: one wait state per access
    // ****************************************
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_q <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0;
        end else begin
            ack_q <= (avs_read || avs_write) && !ack_q;
            avs_waitrequest <= !((avs_read || avs_write) && !ack_q);
            if (rd_req) begin
                case (avs_address)
                    `UBDS_ADDR_DIV_LOW: avs_readdata <= {24'h0, div_low_q};
                    `UBDS_ADDR_DIV_HIGH: avs_readdata <= {24'h0, divisor_high_byte_q};
                    `UBDS_ADDR_MODEM_CTRL: avs_readdata <= {24'h0, modem_control_reg_q};
                    `UBDS_ADDR_FIFO_CTRL: avs_readdata <= {24'h0, fifo_control_reg_q};
                    `UBDS_ADDR_ENH_FEAT: avs_readdata <= {24'h0, enhanced_feature_reg_q};
                    `UBDS_ADDR_INT_ENABLE: avs_readdata <= {24'h0, interrupt_enable_reg_q};
                    `UBDS_ADDR_TRIGGER: avs_readdata <= {24'h0, trigger_q};
                    `UBDS_ADDR_STATUS: avs_readdata <= {8'h0, 1'b0, rx_count_q,
                        1'b0, tx_count_q, fifo_error_q, rx_timeout_q, 3'h0,
                        asleep, rx_dma_request, tx_dma_request};
                    default: avs_readdata <= 32'h0;
                endcase
            end else begin
                avs_readdata <= 32'h0;
            end
        end
    end

    // ****************************************
    // configuration registers
    // ****************************************
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            modem_control_reg_q <= `UBDS_BYTE_ZERO;
            fifo_control_reg_q <= `UBDS_BYTE_ZERO;
            enhanced_feature_reg_q <= `UBDS_BYTE_ZERO;
            interrupt_enable_reg_q <= `UBDS_BYTE_ZERO;
            trigger_q <= `UBDS_BYTE_ZERO;
        end else if (wr_req) begin
            case (avs_address)
                `UBDS_ADDR_MODEM_CTRL: modem_control_reg_q <= avs_writedata[7:0];
                `UBDS_ADDR_FIFO_CTRL: fifo_control_reg_q <= avs_writedata[7:0];
                `UBDS_ADDR_ENH_FEAT: enhanced_feature_reg_q <= avs_writedata[7:0];
                `UBDS_ADDR_INT_ENABLE: interrupt_enable_reg_q <= avs_writedata[7:0];
                `UBDS_ADDR_TRIGGER: trigger_q <= avs_writedata[7:0];
                default: ;
            endcase
        end
    end

    // divisor latches hold across reset
    // byte-wide divisor latches
    always @(posedge clk) begin
        if (wr_req && avs_address == `UBDS_ADDR_DIV_LOW) begin
            div_low_q <= avs_writedata[7:0];
        end
        if (wr_req && avs_address == `UBDS_ADDR_DIV_HIGH) begin
            divisor_high_byte_q <= avs_writedata[7:0];
        end
    end

    // ****************************************
    // fifo occupancy from event pulses
    // ****************************************
    always @* begin
        tx_count_d = tx_count_q;
        rx_count_d = rx_count_q;
        if (wr_req && avs_address == `UBDS_ADDR_EVENT) begin
            if (evt_bit(avs_writedata, `UBDS_EVT_TX_WRITE) && tx_count_q != depth_c)
                tx_count_d = tx_count_d + {{(CW-1){1'b0}}, 1'b1};
            if (evt_bit(avs_writedata, `UBDS_EVT_TX_POP) && tx_count_q != {CW{1'b0}})
                tx_count_d = tx_count_d - {{(CW-1){1'b0}}, 1'b1};
            if (evt_bit(avs_writedata, `UBDS_EVT_RX_PUSH) && rx_count_q != depth_c)
                rx_count_d = rx_count_d + {{(CW-1){1'b0}}, 1'b1};
            if (evt_bit(avs_writedata, `UBDS_EVT_RX_POP) && rx_count_q != {CW{1'b0}})
                rx_count_d = rx_count_d - {{(CW-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_count_q <= {CW{1'b0}};
            rx_count_q <= {CW{1'b0}};
            fifo_error_q <= 1'b0;
            rx_timeout_q <= 1'b0;
            idle_cnt_q <= 10'h0;
            rx_prev_q <= 1'b1;
            modem_prev_q <= 4'hf;
        end else begin
            tx_count_q <= tx_count_d;
            rx_count_q <= rx_count_d;
            rx_prev_q <= rx_s;
            modem_prev_q <= modem_s;
            // set wins over clear
            if (wr_req && avs_address == `UBDS_ADDR_EVENT &&
                evt_bit(avs_writedata, `UBDS_EVT_ERROR_SET))
                fifo_error_q <= 1'b1;
            else if ((wr_req && avs_address == `UBDS_ADDR_EVENT &&
                evt_bit(avs_writedata, `UBDS_EVT_ERROR_CLR)) || rx_count_d == {CW{1'b0}})
                fifo_error_q <= 1'b0;
            // idle count in 16x ticks per bit
            if (!rx_s || rx_count_q == {CW{1'b0}}) begin
                idle_cnt_q <= 10'h0;
            end else if (tick && idle_cnt_q != {timeout_bits[5:0], 4'h0}) begin
                idle_cnt_q <= idle_cnt_q + 10'h1;
            end
            if (rx_count_d == {CW{1'b0}} || rx_count_d != rx_count_q)
                rx_timeout_q <= 1'b0;
            else if (idle_cnt_q == {timeout_bits[5:0], 4'h0})
                rx_timeout_q <= 1'b1;
        end
    end

    // ****************************************
    // dma requests, tick and sleep
    // ****************************************
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_dma_request <= 1'b0;
            rx_dma_request <= 1'b0;
            baud_tick <= 1'b0;
            asleep <= 1'b0;
        end else begin
            baud_tick <= tick;
            if (block_mode) begin
                if (tx_count_d == depth_c)
                    tx_dma_request <= 1'b0;
                else if (depth_c - tx_count_d >= tx_trig)
                    tx_dma_request <= 1'b1;
                if (rx_count_d == {CW{1'b0}} || fifo_error_q)
                    rx_dma_request <= 1'b0;
                else if (rx_count_d >= rx_trig || rx_timeout_q)
                    rx_dma_request <= 1'b1;
            end else begin
                tx_dma_request <= (tx_count_d == {CW{1'b0}});
                rx_dma_request <= (rx_count_d != {CW{1'b0}});
            end
            if (asleep) begin
                // clearing either enable bit also wakes
                if (rx_s != rx_prev_q || modem_s != modem_prev_q || !sleep_allowed ||
                    (evt_wr && evt_bit(avs_writedata, `UBDS_EVT_TX_WRITE)))
                    asleep <= 1'b0;
            end else if (sleep_allowed && sleep_quiet) begin
                asleep <= 1'b1;
            end
        end
    end
endmodule

/* File: rtl/ubds_defs.vh */
// shared constants for the baud, dma and sleep block
`ifndef UBDS_DEFS_VH
`define UBDS_DEFS_VH

// register word addresses (one per register)
`define UBDS_ADDR_DIV_LOW 4'h0
`define UBDS_ADDR_DIV_HIGH 4'h1
`define UBDS_ADDR_MODEM_CTRL 4'h2
`define UBDS_ADDR_FIFO_CTRL 4'h3
`define UBDS_ADDR_ENH_FEAT 4'h4
`define UBDS_ADDR_INT_ENABLE 4'h5
`define UBDS_ADDR_TRIGGER 4'h6
`define UBDS_ADDR_STATUS 4'h7
`define UBDS_ADDR_EVENT 4'h8

// field positions
`define UBDS_MCR_PRESCALE 7
`define UBDS_FCR_FIFO_EN 0
`define UBDS_FCR_DMA_MODE 3
`define UBDS_EFR_ENHANCED 4
`define UBDS_IER_SLEEP 4
`define UBDS_EVT_TX_WRITE 0
`define UBDS_EVT_RX_PUSH 1
`define UBDS_EVT_RX_POP 2
`define UBDS_EVT_TX_POP 3
`define UBDS_EVT_ERROR_SET 4
`define UBDS_EVT_ERROR_CLR 5

// constants
`define UBDS_PRESCALE_DIV 2'h3
`define UBDS_OVERSAMPLE 5'h10
`define UBDS_TIMEOUT_BASE 8'h0c
`define UBDS_WORD_LEN 4'h8
`define UBDS_BYTE_ZERO 8'h00

`endif

/* File: rtl/ubds_sync.v */
// two-flop synchroniser for asynchronous pins
`timescale 1ns/1ps
module ubds_sync #(
    parameter W = 1
) (
    input wire clk,
    input wire rst,
    input wire [W-1:0] async_in,
    output reg [W-1:0] sync_out
);
    reg [W-1:0] meta_q;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= {W{1'b1}};
            sync_out <= {W{1'b1}};
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
